// [core/adcsp_top.sv]
// Serial port clocking and framing for the converter core
`timescale 1ns/1ps
module adcsp_top
  import adcsp_pkg::*;
(
  // Master clock and reset
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  // Serial link
  input  wire logic              sclk_i,
  output logic                   sclk_o,
  output logic                   sclk_oe_o,
  input  wire logic              mode_i,
  input  wire logic              receive_frame_strobe_n_i,
  input  wire logic              transmit_frame_strobe_n_i,
  input  wire logic              register_select_i,
  input  wire logic              sdata_i,
  output logic                   sdata_o,
  output logic                   sdata_oe_o,
  output logic                   result_ready_n_o,
  // Control pins
  input  wire logic              filter_sync_n_i,
  input  wire logic              standby_n_i,
  // Converter side
  input  wire logic [WORD_W-1:0] res_data_i,
  input  wire logic              res_valid_i,
  output logic                   res_ready_o,
  output logic [WORD_W-1:0]      ctrl_o,
  output logic [WORD_W-1:0]      cal_data_o,
  output logic                   cal_valid_o,
  output logic                   filter_reset_o,
  output logic                   power_down_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_m_q, rst_q;

  // Async assert, release through two flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_m_q <= 1'b0;
      rst_q   <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_q   <= rst_m_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin and handshake synchronisers
  // ----------------------------------------------------------------
  logic              rd_t_q, wr_t_q;
  logic [SYNC_W-1:0] s_q;
  logic              mode_s, rfs_s, tfs_s, sd_s, fsync_s, stby_s, sel_s;
  logic              rdt_s, wrt_s;
  logic [1:0]        tg_s;

  adcsp_sync #(.W(SYNC_W)) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_q),
    .d_i     ({mode_i, !receive_frame_strobe_n_i, !transmit_frame_strobe_n_i,
               sdata_i, !filter_sync_n_i, !standby_n_i, register_select_i}),
    .q_o     (s_q)
  );

  adcsp_sync #(.W(2)) u_tog_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_q),
    .d_i     ({rd_t_q, wr_t_q}),
    .q_o     (tg_s)
  );

  // Active-low pins travel inverted, so a reset flop reads as the idle level
  // and no false strobe or sync edge follows reset
  assign {mode_s, rfs_s, tfs_s, sd_s, fsync_s, stby_s} = s_q[SYNC_W-1:1] ^ 6'h1B;
  assign sel_s = s_q[0];
  assign {rdt_s, wrt_s} = tg_s;

  // ----------------------------------------------------------------
  // Result buffer
  // ----------------------------------------------------------------
  adcsp_stream_if #(.W(WORD_W)) head ();

  adcsp_fifo2 u_buf (
    .clk_i      (clk_i),
    .rst_n_i    (rst_q),
    .in_data_i  (res_data_i),
    .in_valid_i (res_valid_i),
    .in_ready_o (res_ready_o),
    .out        (head.prod)
  );

  // ----------------------------------------------------------------
  // Self-clocking engine (master clock domain)
  // ----------------------------------------------------------------
  adcsp_state_t      st_q, st_d;
  logic [PH_W-1:0]   ph_q, ph_d;
  logic [CNT_W-1:0]  cnt_q, cnt_d;
  logic [WORD_W-1:0] sh_q, sh_d;
  logic              sel_q, sel_d;
  logic              sck_q, sck_d, sckoe_q, sckoe_d;
  logic              sd_q, sd_d, sdoe_q, sdoe_d;
  logic              self_rd_done, self_wr_done;

  always_comb begin
    st_d         = st_q;
    ph_d         = ph_q + 3'h1;
    cnt_d        = cnt_q;
    sh_d         = sh_q;
    sel_d        = sel_q;
    sck_d        = sck_q;
    sckoe_d      = sckoe_q;
    sd_d         = sd_q;
    sdoe_d       = sdoe_q;
    self_rd_done = 1'b0;
    self_wr_done = 1'b0;
    case (st_q)
      ST_IDLE: begin
        ph_d    = PH_FALL;
        cnt_d   = '0;
        sckoe_d = 1'b0;
        sdoe_d  = 1'b0;
        sck_d   = 1'b1;
        // Clock only starts on a low strobe, never while powered down
        if (mode_s && stby_s && !rfs_s) begin
          st_d    = ST_READ;
          sckoe_d = 1'b1;
          sel_d   = sel_s;
          sh_d    = sel_s ? head.data : ctrl_o;
        end else if (mode_s && stby_s && !tfs_s) begin
          st_d    = ST_WRITE;
          sckoe_d = 1'b1;
          sel_d   = sel_s;
        end
      end
      ST_READ, ST_WRITE: begin
        // Data moves just after our own falling edge
        if (ph_q == PH_FALL) begin
          sck_d = 1'b0;
          if (st_q == ST_READ) begin
            sd_d   = sh_q[WORD_W-1];
            sh_d   = {sh_q[WORD_W-2:0], 1'b0};
            sdoe_d = 1'b1;
          end
        end
        if (ph_q == PH_RISE) begin
          sck_d = 1'b1;
        end
        // Sample late in the high phase to absorb the pin delay
        if (ph_q == PH_SAMPLE && st_q == ST_WRITE) begin
          sh_d = {sh_q[WORD_W-2:0], sd_s};
        end
        if (ph_q == PH_LAST) begin
          cnt_d = cnt_q + 5'h01;
          if (cnt_q == BIT_LAST) begin
            st_d         = ST_DONE;
            sckoe_d      = 1'b0;
            sdoe_d       = 1'b0;
            self_rd_done = (st_q == ST_READ);
            self_wr_done = (st_q == ST_WRITE);
          end
        end
        // Strobe back high aborts the frame at once
        if ((st_q == ST_READ && rfs_s) || (st_q == ST_WRITE && tfs_s)) begin
          st_d         = ST_IDLE;
          sck_d        = 1'b1;
          sckoe_d      = 1'b0;
          sdoe_d       = 1'b0;
          self_rd_done = 1'b0;
          self_wr_done = 1'b0;
        end
      end
      ST_DONE: begin
        sckoe_d = 1'b0;
        sdoe_d  = 1'b0;
        if (rfs_s && tfs_s) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // Leaving self-clocking mode or entering standby releases the pins
    if (!mode_s || !stby_s) begin
      st_d    = ST_IDLE;
      sckoe_d = 1'b0;
      sdoe_d  = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      st_q    <= ST_IDLE;
      ph_q    <= PH_FALL;
      cnt_q   <= '0;
      sh_q    <= '0;
      sel_q   <= 1'b0;
      sck_q   <= 1'b1;
      sckoe_q <= 1'b0;
      sd_q    <= 1'b0;
      sdoe_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      ph_q    <= ph_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      sel_q   <= sel_d;
      sck_q   <= sck_d;
      sckoe_q <= sckoe_d;
      sd_q    <= sd_d;
      sdoe_q  <= sdoe_d;
    end
  end

  // ----------------------------------------------------------------
  // External clock engine (link domain)
  // ----------------------------------------------------------------
  // Frame counters clear while no strobe is low, so bursts of any
  // length simply resume where the last one stopped.
  logic              lnk_clr;
  logic [CNT_W-1:0]  lrc_q, lrc_d, lwc_q, lwc_d;
  logic              lsd_q, lsd_d, loe_q, loe_d, lrsel_q, lrsel_d;
  logic [WORD_W-1:0] lrx_q, lrx_d, lsrc;
  logic              lwsel_q, lwsel_d, rd_t_d, wr_t_d;

  assign lnk_clr = mode_i | !rst_q |
                   (receive_frame_strobe_n_i & transmit_frame_strobe_n_i);
  // Source words stay put for the whole frame, so this is quasi-static
  assign lsrc = lrsel_d ? head.data : ctrl_o;

  always_comb begin
    lrc_d   = lrc_q;
    lsd_d   = lsd_q;
    loe_d   = loe_q;
    lrsel_d = (lrc_q == 5'h00) ? register_select_i : lrsel_q;
    rd_t_d  = rd_t_q;
    if (!receive_frame_strobe_n_i && lrc_q != BIT_END) begin
      lsd_d = lsrc[BIT_LAST - lrc_q];
      loe_d = 1'b1;
      lrc_d = lrc_q + 5'h01;
      if (lrc_q == BIT_LAST) begin
        rd_t_d = ~rd_t_q;
      end
    end else if (lrc_q == BIT_END) begin
      loe_d = 1'b0;
    end
  end

  // Output shifting on the falling edge
  always_ff @(negedge sclk_i or posedge lnk_clr) begin
    if (lnk_clr) begin
      lrc_q   <= '0;
      lsd_q   <= 1'b0;
      loe_q   <= 1'b0;
      lrsel_q <= 1'b0;
    end else begin
      lrc_q   <= lrc_d;
      lsd_q   <= lsd_d;
      loe_q   <= loe_d;
      lrsel_q <= lrsel_d;
    end
  end

  // Done toggle survives the frame clear so each word signals once
  always_ff @(negedge sclk_i or negedge rst_q) begin
    if (!rst_q) begin
      rd_t_q <= 1'b0;
    end else begin
      rd_t_q <= rd_t_d;
    end
  end

  always_comb begin
    lwc_d   = lwc_q;
    lrx_d   = lrx_q;
    lwsel_d = lwsel_q;
    wr_t_d  = wr_t_q;
    if (!lnk_clr && !transmit_frame_strobe_n_i && lwc_q != BIT_END) begin
      lrx_d = {lrx_q[WORD_W-2:0], sdata_i};
      lwc_d = lwc_q + 5'h01;
      if (lwc_q == 5'h00) begin
        lwsel_d = register_select_i;
      end
      if (lwc_q == BIT_LAST) begin
        wr_t_d = ~wr_t_q;
      end
    end
  end

  // Write counter clears with the frame
  always_ff @(posedge sclk_i or posedge lnk_clr) begin
    if (lnk_clr) begin
      lwc_q <= '0;
    end else begin
      lwc_q <= lwc_d;
    end
  end

  // Received word is held until the next word, long after capture
  always_ff @(posedge sclk_i or negedge rst_q) begin
    if (!rst_q) begin
      lrx_q   <= '0;
      lwsel_q <= 1'b0;
      wr_t_q  <= 1'b0;
    end else begin
      lrx_q   <= lrx_d;
      lwsel_q <= lwsel_d;
      wr_t_q  <= wr_t_d;
    end
  end

  // ----------------------------------------------------------------
  // Word delivery, pins and side outputs (master clock domain)
  // ----------------------------------------------------------------
  logic              rdt_p_q, wrt_p_q, fs_p_q;
  logic [WORD_W-1:0] ctrl_q, ctrl_d, cal_q, cal_d;
  logic              calv_q, calv_d, frst_q, frst_d, pd_q, rdy_n_q;
  logic              ext_rd, ext_wr;
  logic              so_q, soe_q;

  assign ext_rd = rdt_s ^ rdt_p_q;
  assign ext_wr = wrt_s ^ wrt_p_q;
  // Only data reads consume a buffered result
  assign head.ready = (self_rd_done & sel_q) | (ext_rd & lrsel_q);

  always_comb begin
    ctrl_d = ctrl_q;
    cal_d  = cal_q;
    calv_d = 1'b0;
    if (self_wr_done) begin
      if (sel_q) begin
        cal_d  = sh_d;
        calv_d = 1'b1;
      end else begin
        ctrl_d = sh_d;
      end
    end else if (ext_wr) begin
      if (lwsel_q) begin
        cal_d  = lrx_q;
        calv_d = 1'b1;
      end else begin
        ctrl_d = lrx_q;
      end
    end
    frst_d = fs_p_q & !fsync_s;
  end

  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      rdt_p_q <= 1'b0;
      wrt_p_q <= 1'b0;
      fs_p_q  <= 1'b1;
      ctrl_q  <= CTRL_RST;
      cal_q   <= '0;
      calv_q  <= 1'b0;
      frst_q  <= 1'b0;
      pd_q    <= 1'b0;
      rdy_n_q <= 1'b1;
      so_q    <= 1'b0;
      soe_q   <= 1'b0;
    end else begin
      rdt_p_q <= rdt_s;
      wrt_p_q <= wrt_s;
      fs_p_q  <= fsync_s;
      ctrl_q  <= ctrl_d;
      cal_q   <= cal_d;
      calv_q  <= calv_d;
      frst_q  <= frst_d;
      pd_q    <= !stby_s;
      rdy_n_q <= !head.valid;
      so_q    <= sd_q; // one clock after the falling edge
      soe_q   <= sdoe_d;
    end
  end

  // Mode is a static strap; the data pin picks the engine's flops
  assign sdata_o          = mode_i ? so_q : lsd_q;
  assign sdata_oe_o       = mode_i ? soe_q : loe_q;
  assign sclk_o           = sck_q;
  assign sclk_oe_o        = sckoe_q;
  assign result_ready_n_o = rdy_n_q;
  assign ctrl_o           = ctrl_q;
  assign cal_data_o       = cal_q;
  assign cal_valid_o      = calv_q;
  assign filter_reset_o   = frst_q;
  assign power_down_o     = pd_q;

endmodule : adcsp_top

// [core/adcsp_pkg.sv]
// Constants shared by the serial port clocking design
package adcsp_pkg;

  // ----------------------------------------------------------------
  // Word and counter layout
  // ----------------------------------------------------------------
  localparam int          WORD_W   = 24;
  localparam int          CNT_W    = 5;
  localparam logic [4:0]  BIT_LAST = 5'h17;
  localparam logic [4:0]  BIT_END  = 5'h18;

  // ----------------------------------------------------------------
  // Self-clocking divider phases (one serial bit per 8 clocks)
  // ----------------------------------------------------------------
  localparam int          PH_W      = 3;
  localparam logic [2:0]  PH_FALL   = 3'h0;
  localparam logic [2:0]  PH_RISE   = 3'h4;
  localparam logic [2:0]  PH_SAMPLE = 3'h6;
  localparam logic [2:0]  PH_LAST   = 3'h7;

  // ----------------------------------------------------------------
  // Reset values and states
  // ----------------------------------------------------------------
  localparam logic [23:0] CTRL_RST = 24'h000000;
  localparam int          SYNC_W   = 7;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_DONE
  } adcsp_state_t;

endpackage : adcsp_pkg

// [core/adcsp_stream_if.sv]
// Valid/ready word stream between the buffer and the port logic
`timescale 1ns/1ps
interface adcsp_stream_if #(parameter int W = 24);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport prod (output data, output valid, input ready);
  modport cons (input data, input valid, output ready);
endinterface : adcsp_stream_if

// [core/adcsp_sync.sv]
// Two flip-flop level synchroniser, one bit per lane
`timescale 1ns/1ps
module adcsp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  // First stage feeds only the second stage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule : adcsp_sync

// [core/adcsp_fifo2.sv]
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module adcsp_fifo2
  import adcsp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Fill side
  input  wire logic [WORD_W-1:0] in_data_i,
  input  wire logic              in_valid_i,
  output logic                   in_ready_o,
  // Drain side
  adcsp_stream_if.prod           out
);
  logic [WORD_W-1:0] mem_q [2];
  logic              wp_q, wp_d, rp_q, rp_d;
  logic [1:0]        cnt_q, cnt_d;
  logic              vld_q, vld_d, rdy_q, rdy_d;
  logic              push, pop;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Ready and valid are registered so both sides see clean flags
  always_comb begin
    push  = in_valid_i & rdy_q;
    pop   = vld_q & out.ready;
    wp_d  = wp_q ^ push;
    rp_d  = rp_q ^ pop;
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    vld_d = (cnt_d != 2'h0);
    rdy_d = (cnt_d != 2'h2);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
      vld_q    <= 1'b0;
      rdy_q    <= 1'b0;
      mem_q[0] <= '0;
      mem_q[1] <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
      vld_q <= vld_d;
      rdy_q <= rdy_d;
      if (push) begin
        mem_q[wp_q] <= in_data_i;
      end
    end
  end

  assign in_ready_o = rdy_q;
  assign out.valid  = vld_q;
  assign out.data   = mem_q[rp_q];
endmodule : adcsp_fifo2

// [verification/adcsp_top_props.sv]
// Concurrent checks on the serial port clocking top
`timescale 1ns/1ps
module adcsp_top_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Observed pins
  input wire logic mode_i,
  input wire logic receive_frame_strobe_n_i,
  input wire logic transmit_frame_strobe_n_i,
  input wire logic sclk_o,
  input wire logic sclk_oe_o,
  input wire logic sdata_o,
  input wire logic sdata_oe_o,
  input wire logic filter_sync_n_i,
  input wire logic filter_reset_o,
  input wire logic standby_n_i,
  input wire logic power_down_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  logic       idle_w;
  logic       prev_q;
  logic [4:0] fall_q;
  logic [4:0] fall_d;
  assign idle_w = receive_frame_strobe_n_i && transmit_frame_strobe_n_i;

  // Falls of the driven clock in the current frame; cleared once released
  always_comb begin
    fall_d = fall_q;
    if (!sclk_oe_o) fall_d = 5'h00;
    else if (prev_q && !sclk_o) fall_d = fall_q + 5'h01;
  end
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fall_q <= 5'h00;
      prev_q <= 1'b1;
    end else begin
      fall_q <= fall_d;
      prev_q <= sclk_o;
    end
  end

  // ----------------------------------------------------------------
  // Bit period shape: four clocks low, then four high
  // ----------------------------------------------------------------
  sequence low_phase_s;
    !sclk_o [*4] ##1 sclk_o;
  endsequence
  sequence high_phase_s;
    sclk_o [*4];
  endsequence

  a_low_phase: assert property ($fell(sclk_o) |-> low_phase_s)
    else $error("serial clock low phase wrong");
  a_high_phase: assert property ($rose(sclk_o) |-> high_phase_s)
    else $error("serial clock high phase wrong");
  a_clock_start: assert property ($rose(sclk_oe_o) |-> mode_i && !$past(idle_w, 2))
    else $error("clock driven without a frame strobe");
  a_ext_input: assert property (!mode_i |-> !sclk_oe_o)
    else $error("clock pin driven in external mode");
  a_strobe_release: assert property (idle_w [*6] |-> !sclk_oe_o && !sdata_oe_o)
    else $error("pins still driven after strobes high");
  a_fall_count: assert property (sclk_oe_o |-> fall_q <= 5'h18)
    else $error("more than one word of clocks");
  a_word_release: assert property (fall_q == 5'h18 && $rose(sclk_o) |-> ##[0:5] !sclk_oe_o)
    else $error("clock not released after full word");
  a_data_fall: assert property (mode_i && sdata_oe_o && $past(sdata_oe_o) && $changed(sdata_o)
                               |-> $past(sclk_o, 2) && !$past(sclk_o))
    else $error("data changed away from a falling clock");
  a_data_framed: assert property (mode_i && sdata_oe_o |-> sclk_oe_o)
    else $error("data driven without the clock");
  a_sync_pulse: assert property ($fell(filter_sync_n_i) |-> ##[1:4] filter_reset_o)
    else $error("filter reset missing after sync");
  a_pulse_once: assert property (filter_reset_o |=> !filter_reset_o)
    else $error("filter reset longer than one cycle");
  a_standby_on: assert property (!standby_n_i [*6] |-> power_down_o)
    else $error("no power down in standby");
  a_standby_off: assert property (standby_n_i [*6] |-> !power_down_o)
    else $error("power down outside standby");
endmodule : adcsp_top_props

bind adcsp_top adcsp_top_props u_props (
  .clk_i, .resetn_i, .mode_i, .receive_frame_strobe_n_i, .transmit_frame_strobe_n_i,
  .sclk_o, .sclk_oe_o, .sdata_o, .sdata_oe_o, .filter_sync_n_i, .filter_reset_o,
  .standby_n_i, .power_down_o
);

// [verification/adcsp_host.sv]
// Host controller model that frames, clocks and exchanges serial words
`timescale 1ns/1ps
module adcsp_host
  import adcsp_pkg::*;
(
  // Link base clock
  input  wire logic link_clk_i,
  // Pin levels seen by the host
  input  wire logic mode_i,
  input  wire logic sclk_pin_i,
  input  wire logic sdata_pin_i,
  // Host drives
  output logic      sclk_o,
  output logic      rfs_n_o,
  output logic      tfs_n_o,
  output logic      sdata_o
);
  logic wr_act = 1'b0;
  logic wr_bit = 1'b0;
  logic junk_q = 1'b0;
  initial begin
    sclk_o  = 1'b1;
    rfs_n_o = 1'b1;
    tfs_n_o = 1'b1;
  end
  // A released data line shows a changing pattern, never a held value
  always @(posedge link_clk_i) junk_q <= ~junk_q;
  assign sdata_o = wr_act ? wr_bit : junk_q;

  // One frame; stop below a word aborts by raising the strobe after that many bits
  task automatic frame(input bit rd, input logic [WORD_W-1:0] w, input int stop,
                       input bit burst, output logic [WORD_W-1:0] r, output int n);
    logic prev;
    int   k;
    r = '0;
    n = 0;
    prev = 1'b1;
    @(posedge link_clk_i);
    wr_act = !rd;
    wr_bit = w[WORD_W-1];
    if (rd) rfs_n_o = 1'b0;
    else tfs_n_o = 1'b0;
    if (!mode_i) begin
      repeat (8) @(posedge link_clk_i);
      // Half periods of four base clocks keep the link at or below a fifth of master
      while (n < stop) begin
        sclk_o = 1'b0;
        wr_bit = w[WORD_W-1-n];
        repeat (4) @(posedge link_clk_i);
        r = {r[WORD_W-2:0], sdata_pin_i};
        sclk_o = 1'b1;
        repeat (4) @(posedge link_clk_i);
        n++;
        if (burst && n % 8 == 0) repeat (12) @(posedge link_clk_i);
      end
    end else begin
      // Bounded watch of the device clock; a stuck clock shows up as a short count
      for (k = 0; k < 4000 && n < stop; k++) begin
        @(posedge link_clk_i);
        if (sclk_pin_i && !prev) begin
          r = {r[WORD_W-2:0], sdata_pin_i};
          n++;
        end
        if (!sclk_pin_i && prev) wr_bit = w[WORD_W-1-n];
        prev = sclk_pin_i;
      end
    end
    if (stop < WORD_W) begin
      rfs_n_o = 1'b1;
      tfs_n_o = 1'b1;
    end else repeat (10) @(posedge link_clk_i);
  endtask : frame

  // Both strobes high, then enough idle time for the word to reach the core
  task automatic end_frame();
    @(posedge link_clk_i);
    rfs_n_o = 1'b1;
    tfs_n_o = 1'b1;
    wr_act = 1'b0;
    repeat (10) @(posedge link_clk_i);
  endtask : end_frame
endmodule : adcsp_host

// [verification/test_adc_serial_port_clocking.sv]
// Self-checking bench for the serial port clocking top
`timescale 1ns/1ps
module test_adc_serial_port_clocking;
  import adcsp_pkg::*;
  logic              clk_i    = 1'b0;
  logic              link_clk = 1'b1;
  logic              resetn, mode, sel, fsync_n, stby_n, res_valid;
  logic [WORD_W-1:0] res_data, ctrl, cal_data, cal_seen, w, r;
  logic              sclk_o, sclk_oe, sdata_o, sdata_oe, rdy_n, res_ready;
  logic              cal_valid, frst, pdown, h_sclk, rfs_n, tfs_n, h_sd;
  logic              sclk_pin, sd_pin;
  logic [WORD_W-1:0] q[$];
  int                fails = 0;
  int                check_count = 0;
  int                cal_hits = 0;
  int                rst_hits = 0;
  int                n, i, acc;

  always #20 clk_i = ~clk_i; // master clock from a CMOS source, never stopped
  always #16 link_clk = ~link_clk;
  // Board pull-up holds a released clock pin high in self mode
  assign sclk_pin = sclk_oe ? sclk_o : (mode ? 1'b1 : h_sclk);
  assign sd_pin   = sdata_oe ? sdata_o : h_sd;

  adcsp_top DUT (.clk_i(clk_i), .resetn_i(resetn), .sclk_i(sclk_pin), .sclk_o(sclk_o),
    .sclk_oe_o(sclk_oe), .mode_i(mode), .receive_frame_strobe_n_i(rfs_n),
    .transmit_frame_strobe_n_i(tfs_n), .register_select_i(sel), .sdata_i(sd_pin),
    .sdata_o(sdata_o), .sdata_oe_o(sdata_oe), .result_ready_n_o(rdy_n),
    .filter_sync_n_i(fsync_n), .standby_n_i(stby_n), .res_data_i(res_data),
    .res_valid_i(res_valid), .res_ready_o(res_ready), .ctrl_o(ctrl), .cal_data_o(cal_data),
    .cal_valid_o(cal_valid), .filter_reset_o(frst), .power_down_o(pdown));
  adcsp_host host (.link_clk_i(link_clk), .mode_i(mode), .sclk_pin_i(sclk_pin),
    .sdata_pin_i(sd_pin), .sclk_o(h_sclk), .rfs_n_o(rfs_n), .tfs_n_o(tfs_n), .sdata_o(h_sd));

  // Pulses stand a full cycle, so the falling edge sees each exactly once
  always @(negedge clk_i) begin
    if (cal_valid === 1'b1) begin
      cal_hits++;
      cal_seen = cal_data;
    end
    if (frst === 1'b1) rst_hits++;
  end

  task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t ns: got %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    if (fails == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  // Reset for 16 cycles with the mode fixed meanwhile; idle pin levels checked
  task automatic do_reset(input logic m);
    @(negedge clk_i);
    resetn = 1'b0;
    mode = m;
    repeat (16) @(negedge clk_i);
    check(24'({sclk_o, sclk_oe, sdata_oe, rdy_n, res_ready}), 24'h000012);
    resetn = 1'b1;
    repeat (8) @(negedge clk_i);
  endtask : do_reset

  // Offer results for k cycles; ready seen at the falling edge holds to the next rise
  task automatic fill(input int k);
    acc = 0;
    res_valid = 1'b1;
    repeat (k) begin
      res_data = 24'($urandom);
      if (res_ready === 1'b1) begin
        q.push_back(res_data);
        acc++;
      end
      @(negedge clk_i);
    end
    res_valid = 1'b0;
  endtask : fill

  initial begin
    void'($urandom(29319));
    {resetn, mode, sel, fsync_n, stby_n, res_valid, res_data} = {6'h06, 24'h000000};
    do_reset(1'b0);
    // External clock: control words continuous and in bursts, with all-ones and zero
    for (i = 0; i < 4; i++) begin
      w = (i == 0) ? 24'hFFFFFF : (i == 1) ? 24'h000000 : 24'($urandom);
      sel = 1'b0;
      host.frame(1'b0, w, 24, i[0], r, n);
      host.end_frame();
      check(ctrl, w);
      host.frame(1'b1, 24'h000000, 24, !i[0], r, n);
      host.end_frame();
      check(r, w);
    end
    sel = 1'b1;
    w = 24'($urandom);
    host.frame(1'b0, w, 24, 1'b1, r, n);
    host.end_frame();
    check(cal_seen, w);
    check(24'(cal_hits), 24'h000001);
    // Fill the buffer until it refuses, then drain it with a slow host
    fill(6);
    check(24'(acc), 24'h000002);
    check(24'(rdy_n), 24'h000000);
    repeat (2) begin
      host.frame(1'b1, 24'h000000, 24, 1'b1, r, n);
      host.end_frame();
      check(r, q.pop_front());
    end
    check(24'(rdy_n), 24'h000001);
    fsync_n = 1'b0;
    repeat (3) @(negedge clk_i);
    fsync_n = 1'b1;
    repeat (8) @(negedge clk_i);
    check(24'(rst_hits), 24'h000001);
    stby_n = 1'b0;
    repeat (8) @(negedge clk_i);
    check(24'(pdown), 24'h000001);
    stby_n = 1'b1;
    repeat (8) @(negedge clk_i);
    check(24'(pdown), 24'h000000);
    // Self clock: silent until a strobe, full read, write, aborted read, re-read
    do_reset(1'b1);
    repeat (20) @(negedge clk_i);
    check(24'(sclk_oe), 24'h000000);
    fill(1);
    host.frame(1'b1, 24'h000000, 24, 1'b0, r, n);
    check(r, q.pop_front());
    check(24'(sclk_oe), 24'h000000);
    host.end_frame();
    sel = 1'b0;
    w = 24'($urandom);
    host.frame(1'b0, w, 24, 1'b0, r, n);
    host.end_frame();
    check(ctrl, w);
    host.frame(1'b1, 24'h000000, 10, 1'b0, r, n);
    repeat (6) @(negedge clk_i);
    check(24'(sclk_oe), 24'h000000);
    check(r, {14'h0000, w[23:14]});
    host.end_frame();
    host.frame(1'b1, 24'h000000, 24, 1'b0, r, n);
    host.end_frame();
    check(24'(n), 24'h000018);
    check(r, w);
    complete_run();
  end

  // A hang ends the run as a failure
  initial begin
    #3000000;
    fails++;
    complete_run();
  end
endmodule : test_adc_serial_port_clocking
